// File: hdl/pointer_update_unit.sv
// effective address and pointer update for indirect access
`timescale 1ns/1ps
`default_nettype none
`include "sme_params.svh"

module pointer_update_unit
	import sme_pkg::*;
(
	input wire logic [15:0] ptrIn,
	input wire logic [1:0] updateCode,
	input wire logic relative,
	input wire logic [5:0] offset,
	output logic [15:0] effAddr,
	output logic [15:0] ptrOut
);

	// 16-bit sums wrap naturally
	always_comb begin
		effAddr = ptrIn;
		ptrOut = ptrIn;
		if (relative) begin
			effAddr = ptrIn + {{10{offset[5]}}, offset};
		end else begin
			case (updateCode)
				`CODE_PREINC: begin
					effAddr = ptrIn + `PTR_STEP;
					ptrOut = ptrIn + `PTR_STEP;
				end
				`CODE_PREDEC: begin
					effAddr = ptrIn - `PTR_STEP;
					ptrOut = ptrIn - `PTR_STEP;
				end
				`CODE_POSTINC: begin
					ptrOut = ptrIn + `PTR_STEP;
				end
				`CODE_POSTDEC: begin
					ptrOut = ptrIn - `PTR_STEP;
				end
				default: begin
					ptrOut = ptrIn;
				end
			endcase
		end
	end

endmodule

`default_nettype wire

// File: hdl/shift_move_indirect_exec.sv
// execution datapath for shift, move-file and indirect load
`timescale 1ns/1ps
`default_nettype none
`include "sme_params.svh"

// Summary of operation
// - the right shift puts source bits 7..1 into result bits 6..0 and source bit 0 into carry.
// - the right shift forces result bit 7 to zero and sets zero from the shifted result.
// - shift result goes to the accumulator when dest is 0, back to the file register when 1.
// - move-file copies the file register unchanged to the accumulator or back to itself.
// - move-file sets zero when the moved value is zero, so a write-back tests the register.
// - indirect load reads the byte addressed through a pointer into the accumulator.
// - update code 00 is preincrement, 01 predecrement, 10 postincrement, 11 postdecrement.
// - address is pointer+1, pointer-1, pointer, or pointer plus a signed offset of -32..31.
// - afterwards the pointer is one up or one down, and unchanged for offset addressing.
// - the indirect window has no storage; accessing it accesses the location its pointer holds.
// - pointers are 16 bits and wrap around within 0000h..FFFFh.
// - the automatic pointer update never touches carry or zero.

module shift_move_indirect_exec
	import sme_pkg::*;
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic instValid,
	input wire logic [1:0] instOp,
	input wire logic instDest,
	input wire logic [6:0] instFileAddr,
	input wire logic instPtrSel,
	input wire logic [1:0] instUpdateCode,
	input wire logic instRelative,
	input wire logic [5:0] instOffset,
	output logic instReady,
	output logic instDone,
	output logic [15:0] memAddr,
	output logic memRe,
	output logic memWe,
	output logic [7:0] memWdata,
	input wire logic [7:0] memRdata,
	output logic [7:0] accOut,
	output logic carryOut,
	output logic zeroOut,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);

	state_e state_ff, nxt_state;
	logic [7:0] acc_ff, nxt_acc;
	logic carry_ff, nxt_carry;
	logic zero_ff, nxt_zero;
	logic [15:0] ptr0_ff, nxt_ptr0;
	logic [15:0] ptr1_ff, nxt_ptr1;
	logic [1:0] op_ff, nxt_op;
	logic dest_ff, nxt_dest;
	logic sel_ff, nxt_sel;
	logic ptrUpd_ff, nxt_ptrUpd;
	logic [15:0] newPtr_ff, nxt_newPtr;
	logic [15:0] memAddr_ff, nxt_memAddr;
	logic memRe_ff, nxt_memRe;
	logic memWe_ff, nxt_memWe;
	logic [7:0] memWdata_ff, nxt_memWdata;
	logic ready_ff, nxt_ready;
	logic done_ff, nxt_done;
	logic wbAck_ff, nxt_wbAck;
	logic [31:0] wbDat_ff, nxt_wbDat;

	logic ptrIdx;
	logic [15:0] selPtr;
	logic [15:0] unitEff;
	logic [15:0] unitNewPtr;
	logic [7:0] shiftRes;
	logic srcLsb;
	logic accept;
	logic wbReq;

	// true for either indirect window address
	function automatic logic isWindow(input logic [6:0] f);
		isWindow = (f == `WIN0_ADDR) || (f == `WIN1_ADDR);
	endfunction

	// pointer chosen by the instruction or by the window it names
	assign ptrIdx = (instOp == OP_INDIRECT) ? instPtrSel : (instFileAddr == `WIN1_ADDR);
	assign selPtr = ptrIdx ? ptr1_ff : ptr0_ff;
	assign shiftRes = {1'b0, memRdata[7:1]};
	assign srcLsb = memRdata[0];
	assign accept = (state_ff == ST_IDLE) && ready_ff && instValid && (instOp != OP_NONE);
	// bus waits while an instruction is in flight
	assign wbReq = wb_cyc_i && wb_stb_i && !wbAck_ff && (state_ff == ST_IDLE);

	pointer_update_unit ptrUnit (
		.ptrIn(selPtr),
		.updateCode(instUpdateCode),
		.relative(instRelative),
		.offset(instOffset),
		.effAddr(unitEff),
		.ptrOut(unitNewPtr)
	);

	// bus slave next values
	always_comb begin
		nxt_wbAck = wbReq;
		nxt_wbDat = 32'h00000000;
		if (wbReq && !wb_we_i) begin
			case (wb_adr_i)
				`ADR_ACC: nxt_wbDat = {24'h000000, acc_ff};
				`ADR_STATUS: begin
					nxt_wbDat[`STATUS_CARRY_BIT] = carry_ff;
					nxt_wbDat[`STATUS_ZERO_BIT] = zero_ff;
				end
				`ADR_PTR0: nxt_wbDat = {16'h0000, ptr0_ff};
				`ADR_PTR1: nxt_wbDat = {16'h0000, ptr1_ff};
				`ADR_STATE: begin
					nxt_wbDat[2:0] = state_ff;
					nxt_wbDat[`STATE_READY_BIT] = ready_ff;
				end
				default: nxt_wbDat = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			wbAck_ff <= 1'b0;
			wbDat_ff <= 32'h00000000;
		end else begin
			wbAck_ff <= nxt_wbAck;
			wbDat_ff <= nxt_wbDat;
		end
	end

	// datapath and sequencer next values
	always_comb begin
		nxt_state = state_ff;
		nxt_acc = acc_ff;
		nxt_carry = carry_ff;
		nxt_zero = zero_ff;
		nxt_ptr0 = ptr0_ff;
		nxt_ptr1 = ptr1_ff;
		nxt_op = op_ff;
		nxt_dest = dest_ff;
		nxt_sel = sel_ff;
		nxt_ptrUpd = ptrUpd_ff;
		nxt_newPtr = newPtr_ff;
		nxt_memAddr = memAddr_ff;
		nxt_memRe = 1'b0;
		nxt_memWe = 1'b0;
		nxt_memWdata = memWdata_ff;
		nxt_done = 1'b0;
		if (wbReq && wb_we_i) begin
			case (wb_adr_i)
				`ADR_ACC: if (wb_sel_i[0]) nxt_acc = wb_dat_i[7:0];
				`ADR_STATUS: if (wb_sel_i[0]) begin
					nxt_carry = wb_dat_i[`STATUS_CARRY_BIT];
					nxt_zero = wb_dat_i[`STATUS_ZERO_BIT];
				end
				`ADR_PTR0: begin
					if (wb_sel_i[0]) nxt_ptr0[7:0] = wb_dat_i[7:0];
					if (wb_sel_i[1]) nxt_ptr0[15:8] = wb_dat_i[15:8];
				end
				`ADR_PTR1: begin
					if (wb_sel_i[0]) nxt_ptr1[7:0] = wb_dat_i[7:0];
					if (wb_sel_i[1]) nxt_ptr1[15:8] = wb_dat_i[15:8];
				end
				default: nxt_acc = acc_ff;
			endcase
		end
		case (state_ff)
			ST_IDLE: begin
				if (accept) begin
					nxt_state = ST_READ;
					nxt_op = instOp;
					nxt_dest = instDest;
					nxt_sel = ptrIdx;
					nxt_memRe = 1'b1;
					nxt_newPtr = unitNewPtr;
					nxt_ptrUpd = (instOp == OP_INDIRECT) && !instRelative;
					if (instOp == OP_INDIRECT) begin
						nxt_memAddr = unitEff;
					end else if (isWindow(instFileAddr)) begin
						nxt_memAddr = selPtr;
					end else begin
						nxt_memAddr = {9'h000, instFileAddr};
					end
				end
			end
			ST_READ: begin
				nxt_state = ST_EXEC;
			end
			ST_EXEC: begin
				nxt_state = ST_IDLE;
				nxt_done = 1'b1;
				case (op_ff)
					OP_SHIFT: begin
						nxt_carry = srcLsb;
						nxt_zero = (shiftRes == 8'h00);
						if (dest_ff) begin
							nxt_memWe = 1'b1;
							nxt_memWdata = shiftRes;
						end else begin
							nxt_acc = shiftRes;
						end
					end
					OP_MOVE: begin
						nxt_zero = (memRdata == 8'h00);
						if (dest_ff) begin
							nxt_memWe = 1'b1;
							nxt_memWdata = memRdata;
						end else begin
							nxt_acc = memRdata;
						end
					end
					OP_INDIRECT: begin
						nxt_acc = memRdata;
						nxt_zero = (memRdata == 8'h00);
						if (ptrUpd_ff) begin
							if (sel_ff) begin
								nxt_ptr1 = newPtr_ff;
							end else begin
								nxt_ptr0 = newPtr_ff;
							end
						end
					end
					default: nxt_acc = acc_ff;
				endcase
			end
			default: nxt_state = ST_IDLE;
		endcase
		nxt_ready = (nxt_state == ST_IDLE);
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			state_ff <= ST_IDLE;
			acc_ff <= `ACC_RESET;
			carry_ff <= `CARRY_RESET;
			zero_ff <= `ZERO_RESET;
			ptr0_ff <= `PTR_RESET;
			ptr1_ff <= `PTR_RESET;
			op_ff <= OP_NONE;
			dest_ff <= 1'b0;
			sel_ff <= 1'b0;
			ptrUpd_ff <= 1'b0;
			newPtr_ff <= `PTR_RESET;
			memAddr_ff <= 16'h0000;
			memRe_ff <= 1'b0;
			memWe_ff <= 1'b0;
			memWdata_ff <= 8'h00;
			ready_ff <= 1'b0;
			done_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			acc_ff <= nxt_acc;
			carry_ff <= nxt_carry;
			zero_ff <= nxt_zero;
			ptr0_ff <= nxt_ptr0;
			ptr1_ff <= nxt_ptr1;
			op_ff <= nxt_op;
			dest_ff <= nxt_dest;
			sel_ff <= nxt_sel;
			ptrUpd_ff <= nxt_ptrUpd;
			newPtr_ff <= nxt_newPtr;
			memAddr_ff <= nxt_memAddr;
			memRe_ff <= nxt_memRe;
			memWe_ff <= nxt_memWe;
			memWdata_ff <= nxt_memWdata;
			ready_ff <= nxt_ready;
			done_ff <= nxt_done;
		end
	end

	assign instReady = ready_ff;
	assign instDone = done_ff;
	assign memAddr = memAddr_ff;
	assign memRe = memRe_ff;
	assign memWe = memWe_ff;
	assign memWdata = memWdata_ff;
	assign accOut = acc_ff;
	assign carryOut = carry_ff;
	assign zeroOut = zero_ff;
	assign wb_dat_o = wbDat_ff;
	assign wb_ack_o = wbAck_ff;

	// checks
	logic execShift;
	logic execMove;
	logic execInd;
	assign execShift = (state_ff == ST_EXEC) && (op_ff == OP_SHIFT);
	assign execMove = (state_ff == ST_EXEC) && (op_ff == OP_MOVE);
	assign execInd = (state_ff == ST_EXEC) && (op_ff == OP_INDIRECT);

	sequence s_accept;
		accept;
	endsequence

	sequence s_run;
		(state_ff == ST_READ) ##1 (state_ff == ST_EXEC) ##1 done_ff;
	endsequence

	property p_shift_acc;
		@(posedge clock) disable iff (!rstn)
		execShift && !dest_ff |=> acc_ff == $past(shiftRes) && !acc_ff[7];
	endproperty
	a_shift_acc: assert property (p_shift_acc) else $error("shift result wrong");

	property p_shift_carry;
		@(posedge clock) disable iff (!rstn)
		execShift |=> carry_ff == $past(srcLsb) && zero_ff == ($past(shiftRes) == 8'h00);
	endproperty
	a_shift_carry: assert property (p_shift_carry) else $error("shift flags wrong");

	property p_shift_back;
		@(posedge clock) disable iff (!rstn)
		execShift && dest_ff |=> memWe_ff && memWdata_ff == $past(shiftRes)
			&& memAddr_ff == $past(memAddr_ff) && $stable(acc_ff);
	endproperty
	a_shift_back: assert property (p_shift_back) else $error("shift write-back wrong");

	property p_move;
		@(posedge clock) disable iff (!rstn)
		execMove |=> zero_ff == ($past(memRdata) == 8'h00)
			&& (dest_ff ? memWdata_ff == $past(memRdata) : acc_ff == $past(memRdata));
	endproperty
	a_move: assert property (p_move) else $error("move result wrong");

	property p_ind_load;
		@(posedge clock) disable iff (!rstn)
		execInd |=> acc_ff == $past(memRdata) && zero_ff == (acc_ff == 8'h00)
			&& $stable(carry_ff);
	endproperty
	a_ind_load: assert property (p_ind_load) else $error("indirect load wrong");

	property p_preinc_addr;
		@(posedge clock) disable iff (!rstn)
		accept && instOp == OP_INDIRECT && !instRelative && instUpdateCode == `CODE_PREINC
			|=> memAddr_ff == 16'($past(selPtr) + `PTR_STEP) && memRe_ff;
	endproperty
	a_preinc_addr: assert property (p_preinc_addr) else $error("preincrement address wrong");

	property p_postdec_ptr;
		@(posedge clock) disable iff (!rstn)
		accept && instOp == OP_INDIRECT && !instRelative && instUpdateCode == `CODE_POSTDEC
			&& !instPtrSel |=> memAddr_ff == $past(selPtr)
			##2 ptr0_ff == 16'($past(ptr0_ff, 3) - `PTR_STEP);
	endproperty
	a_postdec_ptr: assert property (p_postdec_ptr) else $error("postdecrement wrong");

	property p_window;
		@(posedge clock) disable iff (!rstn)
		accept && instOp != OP_INDIRECT && isWindow(instFileAddr) |=> memAddr_ff == $past(selPtr);
	endproperty
	a_window: assert property (p_window) else $error("window address wrong");

	property p_one_cycle;
		@(posedge clock) disable iff (!rstn)
		s_accept |=> s_run;
	endproperty
	a_one_cycle: assert property (p_one_cycle) else $error("instruction timing wrong");

endmodule

`default_nettype wire

// File: hdl/sme_params.svh
// constants for the shift, move-file and indirect load datapath
`ifndef SME_PARAMS_SVH
`define SME_PARAMS_SVH

// register byte offsets on the wishbone slave
`define ADR_ACC 8'h00
`define ADR_STATUS 8'h04
`define ADR_PTR0 8'h08
`define ADR_PTR1 8'h0C
`define ADR_STATE 8'h10

// status field positions
`define STATUS_CARRY_BIT 0
`define STATUS_ZERO_BIT 1

// state register field positions
`define STATE_READY_BIT 3

// reset values
`define ACC_RESET 8'h00
`define PTR_RESET 16'h0000
`define CARRY_RESET 1'b0
`define ZERO_RESET 1'b0

// file addresses of the two indirect windows
`define WIN0_ADDR 7'h00
`define WIN1_ADDR 7'h01

// pointer update codes
`define CODE_PREINC 2'h0
`define CODE_PREDEC 2'h1
`define CODE_POSTINC 2'h2
`define CODE_POSTDEC 2'h3

// pointer step and cycles from accept to done
`define PTR_STEP 16'h0001
`define INST_CYCLES 3

`endif

// File: hdl/sme_pkg.sv
// types for the shift, move-file and indirect load datapath
package sme_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_READ = 3'b010,
		ST_EXEC = 3'b100
	} state_e;

	typedef enum logic [1:0] {
		OP_NONE = 2'h0,
		OP_SHIFT = 2'h1,
		OP_MOVE = 2'h2,
		OP_INDIRECT = 2'h3
	} op_e;

endpackage

// File: verif/data_mem_model.sv
// data memory partner for the execution datapath
`timescale 1ns/1ps
`default_nettype none

module data_mem_model (
	input wire logic clock,
	input wire logic [15:0] memAddr,
	input wire logic memRe,
	input wire logic memWe,
	input wire logic [7:0] memWdata,
	output logic [7:0] memRdata
);
	logic [7:0] store [int];

	task automatic poke(input int a, input logic [7:0] d);
		store[a] = d;
	endtask

	always @(posedge clock) begin
		if (memWe) begin
			store[int'(memAddr)] = memWdata;
		end
		if (memRe && store.exists(int'(memAddr))) begin
			memRdata <= store[int'(memAddr)];
		end else begin
			// data only valid the cycle after the read strobe
			memRdata <= ~memRdata;
		end
	end
endmodule

`default_nettype wire

// File: verif/shift_move_indirect_exec_tb.sv
// self-checking bench for the shift, move-file and indirect load datapath
`timescale 1ns/1ps
`default_nettype none
`include "sme_params.svh"

module shift_move_indirect_exec_tb
	import sme_pkg::*;
;
	logic clock = 1'b0;
	logic rstn, instValid, instDest, instPtrSel, instRelative, instReady, instDone;
	logic [1:0] instOp, instUpdateCode, op;
	logic [6:0] instFileAddr;
	logic [5:0] instOffset;
	logic [15:0] memAddr;
	logic memRe, memWe, carryOut, zeroOut, cy, zf;
	logic [7:0] memWdata, memRdata, accOut, acc;
	logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, q, k;
	logic [15:0] ptr [2];
	int errTotal, checksDone, seed, i;
	logic hung = 1'b0;

	always #50 clock = ~clock;

	shift_move_indirect_exec u_dut (.clock(clock), .rstn(rstn), .instValid(instValid),
		.instOp(instOp), .instDest(instDest), .instFileAddr(instFileAddr),
		.instPtrSel(instPtrSel), .instUpdateCode(instUpdateCode),
		.instRelative(instRelative), .instOffset(instOffset), .instReady(instReady),
		.instDone(instDone), .memAddr(memAddr), .memRe(memRe), .memWe(memWe),
		.memWdata(memWdata), .memRdata(memRdata), .accOut(accOut), .carryOut(carryOut),
		.zeroOut(zeroOut), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

	data_mem_model u_mem (.clock(clock), .memAddr(memAddr), .memRe(memRe),
		.memWe(memWe), .memWdata(memWdata), .memRdata(memRdata));

	task automatic tallyAndFinish();
		if (errTotal == 0 && checksDone > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checksDone++;
		if (seen !== exp) begin
			errTotal++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] sel,
		input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= sel;
		wb_dat_i <= d;
		do begin
			@(posedge clock);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (n >= 20) hung = 1'b1;
		r = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clock);
		check("bus wait", n < 20, 1'b1);
	endtask

	task automatic run(input logic [1:0] o, input logic d, input logic [6:0] fa,
		input logic ps, input logic [1:0] uc, input logic rel, input logic [5:0] off);
		logic [15:0] p, ea, np;
		logic [7:0] src, res;
		logic wr, sel;
		int n, m;
		sel = (o == OP_INDIRECT) ? ps : fa[0];
		p = ptr[sel];
		ea = (o != OP_INDIRECT && fa > 7'h01) ? {9'h000, fa} : p;
		np = p;
		if (o == OP_INDIRECT && rel) begin
			ea = p + {{10{off[5]}}, off};
		end else if (o == OP_INDIRECT) begin
			np = uc[0] ? p - 16'h0001 : p + 16'h0001;
			ea = uc[1] ? p : np;
		end
		src = 8'($random(seed));
		src = (src[6:4] == 3'h0) ? {7'h00, src[0]} : src;
		res = (o == OP_SHIFT) ? {1'b0, src[7:1]} : src;
		wr = (o != OP_INDIRECT) && d;
		cy = (o == OP_SHIFT) ? src[0] : cy;
		zf = (res == 8'h00);
		acc = wr ? acc : res;
		ptr[sel] = np;
		instValid <= 1'b1;
		instOp <= o;
		instDest <= d;
		instFileAddr <= fa;
		instPtrSel <= ps;
		instUpdateCode <= uc;
		instRelative <= rel;
		instOffset <= off;
		n = 0;
		m = 0;
		do begin
			@(posedge clock);
			n++;
		end while (instReady !== 1'b1 && n < 20);
		instValid <= 1'b0;
		check("ready wait", n < 20, 1'b1);
		u_mem.poke(ea, src);
		do begin
			@(posedge clock);
			m++;
		end while (instDone !== 1'b1 && m < 20);
		if (n >= 20 || m >= 20) hung = 1'b1;
		check("latency", m, `INST_CYCLES);
		check("acc", accOut, acc);
		check("carry", carryOut, cy);
		check("zero", zeroOut, zf);
		check("addr", memAddr, ea);
		check("write", memWe, wr);
		check("wdata", wr ? memWdata : res, res);
		if (o == OP_INDIRECT) begin
			wb(1'b0, sel ? `ADR_PTR1 : `ADR_PTR0, 4'hF, 32'h0, q);
			check("pointer", q, {16'h0000, np});
		end
	endtask

	initial begin
		for (int w = 0; w < 50000 && !hung; w++) begin
			@(posedge clock);
		end
		errTotal++;
		tallyAndFinish();
	end

	initial begin
		seed = 58;
		{rstn, instValid, instDest, instPtrSel, instRelative, instOp} = '0;
		{instUpdateCode, instFileAddr, instOffset} = '0;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
		{acc, cy, zf, ptr[0], ptr[1]} = '0;
		repeat (6) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		@(posedge clock);
		for (i = 0; i < 4; i++) begin
			wb(1'b0, 8'(i * 4), 4'hF, 32'h0, q);
			check("reset", q, 32'h0);
		end
		wb(1'b0, `ADR_STATE, 4'hF, 32'h0, q);
		check("state", q, {28'h0, 1'b1, ST_IDLE});
		wb(1'b1, 8'h20, 4'hF, 32'hFFFFFFFF, q);
		wb(1'b0, 8'h20, 4'hF, 32'h0, q);
		check("unmapped", q, 32'h0);
		wb(1'b1, `ADR_PTR0, 4'hF, 32'h0000FFFF, q);
		ptr[0] = 16'hFFFF;
		wb(1'b1, `ADR_STATUS, 4'hF, 32'h1, q);
		cy = 1'b1;
		for (i = 0; i < 24; i++) begin
			k = $random(seed);
			run(i[0] ? OP_MOVE : OP_SHIFT, k[7], (i < 4) ? 7'(i % 2) : k[6:0], 1'b0, 2'h0,
				1'b0, 6'h00);
		end
		for (i = 0; i < 8; i++) begin
			run(OP_INDIRECT, 1'b0, 7'h00, i[2], i[1:0], 1'b0, 6'h00);
		end
		run(OP_INDIRECT, 1'b0, 7'h00, 1'b0, 2'h0, 1'b1, 6'h20);
		run(OP_INDIRECT, 1'b0, 7'h00, 1'b1, 2'h3, 1'b1, 6'h1F);
		wb(1'b1, `ADR_PTR0, 4'h1, 32'h0000ABCD, q);
		ptr[0] = {ptr[0][15:8], 8'hCD};
		wb(1'b0, `ADR_PTR0, 4'hF, 32'h0, q);
		check("ptr0 low byte", q, {16'h0000, ptr[0]});
		k = $random(seed);
		wb(1'b1, `ADR_ACC, 4'h1, k, q);
		acc = k[7:0];
		wb(1'b0, `ADR_ACC, 4'hF, 32'h0, q);
		check("acc write", q, {24'h000000, acc});
		wb(1'b0, `ADR_STATUS, 4'hF, 32'h0, q);
		check("status", q, {30'h0, zf, cy});
		instValid <= 1'b1;
		instOp <= OP_NONE;
		for (i = 0; i < 4; i++) begin
			@(posedge clock);
			check("idle op", {instDone, memRe}, 2'b00);
		end
		instValid <= 1'b0;
		@(posedge clock);
		for (i = 0; i < 60; i++) begin
			k = $random(seed);
			op = (k[1:0] == 2'h0) ? 2'h3 : k[1:0];
			run(op, k[2], k[9:3], k[10], k[12:11], k[13], k[19:14]);
		end
		tallyAndFinish();
	end
endmodule

`default_nettype wire
